// ==== gpmf_io.sv ====
/*
  gpmf_io: pin logic for 7 general purpose ports and 32 multi-function ports.
  assumes pads outside resolve out/oe/pull-down; control bits arrive as plain ports
  from a register file elsewhere; inputs are synchronous to clk_sys.
*/
// Overview of operation
// - seven general purpose pins, each input or output by software
// - each software port yields separate rising and falling event pulses
// - general purpose inputs pass a 16 to 24 ms debounce filter
// - debounce select picks filtered or direct; feeds input bit and edge detect
// - general purpose input bit reads pin level whatever the direction
// - general purpose pad value from output bit, enable from direction bit
// - per-pin power-down enable forces output low and pull-down on power-down
// - power-down is true when either supply-good input is low
// - thirty-two multi-function pins, software port or standard function
// - multi-function input undebounced to input bit, edges and function module
// - multi-function pad value muxed between software bit and function output
// - multi-function enable muxed between direction bit and function direction
// - multi-function output gated low with pull-down when power-down and bit set
// - select reset value has ones at 31-28, 25, 19-16, 11-0
// - power-down enable reset value zero at 26, 24, 19-14, else one
// - multi-function rising edges set status bank three bits
// - multi-function falling edges set status bank four bits
// - pins 1 and 0 carry test outputs as alternate function
// - pins map to standard functions by index
// - select one means software port, zero means standard function
// - debounce select one uses filter, zero bypasses it
// - direction one drives the pin, zero leaves it input
`timescale 1ns/1ps
module gpmf_io
  import gpmf_pkg::*;
#(
  parameter int unsigned GP_N       = GP_PORTS,
  parameter int unsigned MF_N       = MF_PORTS,
  parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // supply-good levels
  input  wire logic              supply_good_main,
  input  wire logic              supply_good_core,
  // general purpose control
  input  wire logic [GP_N-1:0]   gp_direction,
  input  wire logic [GP_N-1:0]   gp_output_value,
  input  wire logic [GP_N-1:0]   gp_debounce_select,
  input  wire logic [GP_N-1:0]   gp_powerdown_enable,
  input  wire logic              gp_ctrl_load,
  // multi-function control
  input  wire logic [MF_N-1:0]   mf_direction,
  input  wire logic [MF_N-1:0]   mf_output_value,
  input  wire logic [MF_N-1:0]   mf_port_select_in,
  input  wire logic [MF_N-1:0]   mf_powerdown_in,
  input  wire logic              mf_ctrl_load,
  // standard function modules
  input  wire logic [MF_N-1:0]   func_out,
  input  wire logic [MF_N-1:0]   func_oe,
  input  wire logic              bus_master_test,
  input  wire logic              cpu_data_cycle_test,
  // pads
  input  wire logic [GP_N-1:0]   gp_pad_in,
  output logic      [GP_N-1:0]   gp_pad_out,
  output logic      [GP_N-1:0]   gp_pad_oe,
  output logic      [GP_N-1:0]   gp_pad_pulldown,
  input  wire logic [MF_N-1:0]   mf_pad_in,
  output logic      [MF_N-1:0]   mf_pad_out,
  output logic      [MF_N-1:0]   mf_pad_oe,
  output logic      [MF_N-1:0]   mf_pad_pulldown,
  // readback and events
  output logic      [GP_N-1:0]   gp_input_value,
  output logic      [MF_N-1:0]   mf_input_value,
  output logic      [MF_N-1:0]   mf_func_in,
  output logic      [MF_N-1:0]   mf_port_select_bits,
  output logic      [MF_N-1:0]   mf_powerdown_bits,
  output logic                   powered_down,
  output logic      [GP_N-1:0]   gp_rise_event,
  output logic      [GP_N-1:0]   gp_fall_event,
  output logic      [MF_N-1:0]   mf_rise_event,
  output logic      [MF_N-1:0]   mf_fall_event
);
  // shared pin driver: gate value low when powered down and pd_en set; pull-down is driven separately
  function automatic logic gate_out(input logic val, input logic pd_en, input logic pd);
    gate_out = val & ~(pd_en & pd);
  endfunction

  localparam int unsigned TICK_W = $clog2(TICK_COUNT + 1);

  // control state: select and power-down banks held here with documented resets
  logic [MF_N-1:0]   next_mf_port_select_bits;
  logic [MF_N-1:0]   next_mf_powerdown_bits;
  logic [TICK_W-1:0] tick_count;
  logic [TICK_W-1:0] next_tick_count;
  logic              tick;
  logic              next_tick;
  logic [GP_N-1:0]   gp_pd_bits;
  logic [GP_N-1:0]   next_gp_pd_bits;

  always_comb begin
    next_mf_port_select_bits = mf_port_select_bits;
    next_mf_powerdown_bits   = mf_powerdown_bits;
    next_gp_pd_bits          = gp_pd_bits;
    if (mf_ctrl_load) begin
      next_mf_port_select_bits = mf_port_select_in;
      next_mf_powerdown_bits   = mf_powerdown_in;
    end
    if (gp_ctrl_load) begin
      next_gp_pd_bits = gp_powerdown_enable;
    end
    next_tick       = 1'b0;
    next_tick_count = tick_count + 1'b1;
    if (tick_count == TICK_W'(TICK_COUNT - 1)) begin
      next_tick_count = '0;
      next_tick       = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mf_port_select_bits <= MF_SEL_RST[MF_N-1:0];
      mf_powerdown_bits   <= MF_PD_RST[MF_N-1:0];
      gp_pd_bits          <= GP_PD_RST[GP_N-1:0];
      tick_count          <= '0;
      tick                <= 1'b0;
    end else begin
      mf_port_select_bits <= next_mf_port_select_bits;
      mf_powerdown_bits   <= next_mf_powerdown_bits;
      gp_pd_bits          <= next_gp_pd_bits;
      tick_count          <= next_tick_count;
      tick                <= next_tick;
    end
  end

  // debounce filters, one per general purpose pin
  logic [GP_N-1:0] gp_filtered;
  for (genvar g = 0; g < GP_N; g++) begin : g_deb
    gpmf_debounce #(
      .STABLE_TICKS (DEB_TICKS)
    ) u_deb (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .tick     (tick),
      .raw_in   (gp_pad_in[g]),
      .filt_out (gp_filtered[g])
    );
  end

  // alternate function sources; pins 1 and 0 carry the test signals
  logic [MF_N-1:0] func_out_all;
  logic [MF_N-1:0] func_oe_all;
  always_comb begin
    func_out_all    = func_out;
    func_oe_all     = func_oe;
    func_out_all[1] = bus_master_test;
    func_out_all[0] = cpu_data_cycle_test;
    func_oe_all[1]  = 1'b1;
    func_oe_all[0]  = 1'b1;
  end

  // pin path next values
  logic            next_powered_down;
  logic [GP_N-1:0] gp_sel_in;
  logic [GP_N-1:0] next_gp_pad_out;
  logic [GP_N-1:0] next_gp_pad_oe;
  logic [GP_N-1:0] next_gp_pad_pulldown;
  logic [MF_N-1:0] next_mf_pad_out;
  logic [MF_N-1:0] next_mf_pad_oe;
  logic [MF_N-1:0] next_mf_pad_pulldown;
  logic [GP_N-1:0] next_gp_rise_event;
  logic [GP_N-1:0] next_gp_fall_event;
  logic [MF_N-1:0] next_mf_rise_event;
  logic [MF_N-1:0] next_mf_fall_event;

  always_comb begin
    next_powered_down = ~(supply_good_main & supply_good_core);
    gp_sel_in = (gp_debounce_select & gp_filtered)
              | (~gp_debounce_select & gp_pad_in);
    for (int i = 0; i < GP_N; i++) begin
      // output enable cleared during power-down for pins with the power-down bit set, so the pull-down sets the pin level
      next_gp_pad_out[i]      = gate_out(gp_output_value[i], gp_pd_bits[i], powered_down);
      next_gp_pad_oe[i]       = gp_direction[i] & ~(gp_pd_bits[i] & powered_down);
      next_gp_pad_pulldown[i] = gp_pd_bits[i] & powered_down;
    end
    for (int i = 0; i < MF_N; i++) begin
      // select one: software port; zero: standard function per index map
      next_mf_pad_out[i] = gate_out(mf_port_select_bits[i] ? mf_output_value[i] : func_out_all[i],
                                    mf_powerdown_bits[i], powered_down);
      next_mf_pad_oe[i]  = (mf_port_select_bits[i] ? mf_direction[i] : func_oe_all[i])
                           & ~(mf_powerdown_bits[i] & powered_down);
      next_mf_pad_pulldown[i] = mf_powerdown_bits[i] & powered_down;
    end
    // compare new sample with registered one; pulses last one cycle
    next_gp_rise_event = gp_sel_in & ~gp_input_value;
    next_gp_fall_event = ~gp_sel_in & gp_input_value;
    next_mf_rise_event = mf_pad_in & ~mf_input_value & mf_port_select_bits;
    next_mf_fall_event = ~mf_pad_in & mf_input_value & mf_port_select_bits;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powered_down    <= 1'b0;
      gp_pad_out      <= '0;
      gp_pad_oe       <= '0;
      gp_pad_pulldown <= '0;
      mf_pad_out      <= '0;
      mf_pad_oe       <= '0;
      mf_pad_pulldown <= '0;
      gp_input_value  <= '0;
      mf_input_value  <= '0;
      mf_func_in      <= '0;
      gp_rise_event   <= '0;
      gp_fall_event   <= '0;
      mf_rise_event   <= '0;
      mf_fall_event   <= '0;
    end else begin
      powered_down    <= next_powered_down;
      gp_pad_out      <= next_gp_pad_out;
      gp_pad_oe       <= next_gp_pad_oe;
      gp_pad_pulldown <= next_gp_pad_pulldown;
      mf_pad_out      <= next_mf_pad_out;
      mf_pad_oe       <= next_mf_pad_oe;
      mf_pad_pulldown <= next_mf_pad_pulldown;
      gp_input_value  <= gp_sel_in;
      mf_input_value  <= mf_pad_in;
      mf_func_in      <= mf_pad_in;
      gp_rise_event   <= next_gp_rise_event;
      gp_fall_event   <= next_gp_fall_event;
      mf_rise_event   <= next_mf_rise_event;
      mf_fall_event   <= next_mf_fall_event;
    end
  end
endmodule // gpmf_io

// ==== gpmf_pkg.sv ====
/*
  gpmf_pkg: constants shared by the general purpose / multi-function pin block.
  assumes a 20 MHz system clock; all widths, reset values and cycle counts live here.
*/
package gpmf_pkg;
  localparam int unsigned GP_PORTS     = 7;
  localparam int unsigned MF_PORTS     = 32;
  localparam int unsigned CLK_HZ       = 20_000_000;
  // debounce timed from a 1 ms tick; stable for 16..24 ms window
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned DEB_MIN_MS   = 16;
  localparam int unsigned DEB_MAX_MS   = 24;
  localparam int unsigned DEB_TICKS    = DEB_MIN_MS + 1;
  localparam int unsigned DEB_CNT_W    = 5;
  localparam logic [31:0] MF_SEL_RST   = 32'hf20f0fff;
  // only pins 26, 24 and 19..14 stay active through power-down after reset
  localparam logic [31:0] MF_PD_RST    = 32'hfaf03fff;
  localparam logic [6:0]  GP_PD_RST    = 7'h7f;
  localparam logic [6:0]  GP_DIR_RST   = 7'h00;
  localparam logic [31:0] MF_DIR_RST   = 32'h00000000;
  localparam logic [6:0]  GP_DEB_RST   = 7'h00;
  localparam logic [6:0]  GP_OUT_RST   = 7'h00;
  localparam logic [31:0] MF_OUT_RST   = 32'h00000000;
endpackage : gpmf_pkg

// ==== gpmf_debounce.sv ====
/*
  gpmf_debounce: one-pin debounce filter driven by a shared slow tick.
  assumes input already synchronous to clk_sys and a one-cycle tick pulse.
*/
`timescale 1ns/1ps
module gpmf_debounce
  import gpmf_pkg::*;
#(
  parameter int unsigned STABLE_TICKS = DEB_TICKS
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic raw_in,
  output logic      filt_out
);
  logic [DEB_CNT_W-1:0] count;
  logic [DEB_CNT_W-1:0] next_count;
  logic                 next_filt_out;

  // counts whole ticks of stability; a partial first tick makes the window 16..17 ms
  always_comb begin
    next_count    = count;
    next_filt_out = filt_out;
    if (raw_in == filt_out) begin
      next_count = '0;
    end else if (tick) begin
      if (count == DEB_CNT_W'(STABLE_TICKS - 1)) begin
        next_filt_out = raw_in;
        next_count    = '0;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count    <= '0;
      filt_out <= 1'b0;
    end else begin
      count    <= next_count;
      filt_out <= next_filt_out;
    end
  end
endmodule // gpmf_debounce

// ==== gpmf_io_props.sv ====
/* gpmf_io_props: timing relations between gpmf_io inputs and its registered pad, readback and event outputs.
   assumes it is bound into gpmf_io and that rst is synchronous and active high. */
`timescale 1ns/1ps
module gpmf_io_props
  import gpmf_pkg::*;
#(
  parameter int unsigned GP_N = GP_PORTS,
  parameter int unsigned MF_N = MF_PORTS
) (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            supply_good_main,
  input wire logic            supply_good_core,
  input wire logic [GP_N-1:0] gp_direction,
  input wire logic [GP_N-1:0] gp_output_value,
  input wire logic [GP_N-1:0] gp_debounce_select,
  input wire logic [GP_N-1:0] gp_pad_in,
  input wire logic [GP_N-1:0] gp_pad_out,
  input wire logic [GP_N-1:0] gp_pad_oe,
  input wire logic [GP_N-1:0] gp_pad_pulldown,
  input wire logic [GP_N-1:0] gp_input_value,
  input wire logic [GP_N-1:0] gp_rise_event,
  input wire logic [GP_N-1:0] gp_fall_event,
  input wire logic [MF_N-1:0] mf_direction,
  input wire logic [MF_N-1:0] mf_output_value,
  input wire logic [MF_N-1:0] func_out,
  input wire logic [MF_N-1:0] func_oe,
  input wire logic            bus_master_test,
  input wire logic            cpu_data_cycle_test,
  input wire logic [MF_N-1:0] mf_pad_in,
  input wire logic [MF_N-1:0] mf_pad_out,
  input wire logic [MF_N-1:0] mf_pad_oe,
  input wire logic [MF_N-1:0] mf_pad_pulldown,
  input wire logic [MF_N-1:0] mf_input_value,
  input wire logic [MF_N-1:0] mf_port_select_bits,
  input wire logic [MF_N-1:0] mf_powerdown_bits,
  input wire logic            powered_down,
  input wire logic [MF_N-1:0] mf_rise_event,
  input wire logic [MF_N-1:0] mf_fall_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [MF_N-1:0] gate, exp_o, exp_e, exp_p;
  assign gate = mf_powerdown_bits & {MF_N{powered_down}};
  // pads are one register behind the mux inputs, so the expected value is registered too
  always_ff @(posedge clk_sys) begin
    exp_o <= ~gate & ((mf_port_select_bits & mf_output_value) |
                      (~mf_port_select_bits & {func_out[MF_N-1:2], bus_master_test, cpu_data_cycle_test}));
    exp_e <= ~gate & ((mf_port_select_bits & mf_direction) | (~mf_port_select_bits & {func_oe[MF_N-1:2], 2'h3}));
    exp_p <= gate;
  end
  reset_value_a: assert property ($past(rst) |-> mf_port_select_bits == MF_SEL_RST && mf_powerdown_bits == MF_PD_RST)
    else $error("select or power-down bank wrong after reset");
  supply_gate_a: assert property (!$past(rst) |-> powered_down == !($past(supply_good_main) && $past(supply_good_core)))
    else $error("powered_down does not follow the supplies");
  mf_pad_val_a: assert property (!$past(rst) |-> mf_pad_out == exp_o)
    else $error("mf pad value wrong");
  mf_pad_dir_a: assert property (!$past(rst) |-> mf_pad_oe == exp_e)
    else $error("mf pad enable wrong");
  mf_pull_dn_a: assert property (!$past(rst) |-> mf_pad_pulldown == exp_p)
    else $error("mf pull-down wrong");
  mf_readback_a: assert property (!$past(rst) |-> mf_input_value == $past(mf_pad_in))
    else $error("mf input value does not follow the pin");
  mf_rise_evt_a: assert property (!$past(rst) |-> (mf_rise_event & ~(mf_input_value & ~$past(mf_input_value))) == 0 &&
    (mf_input_value & ~$past(mf_input_value) & mf_port_select_bits & $past(mf_port_select_bits) & ~mf_rise_event) == 0)
    else $error("mf rising event wrong");
  mf_fall_evt_a: assert property (!$past(rst) |-> (mf_fall_event & ~(~mf_input_value & $past(mf_input_value))) == 0 &&
    (~mf_input_value & $past(mf_input_value) & mf_port_select_bits & $past(mf_port_select_bits) & ~mf_fall_event) == 0)
    else $error("mf falling event wrong");
  gp_edge_evt_a: assert property (!$past(rst) |-> gp_rise_event == (gp_input_value & ~$past(gp_input_value)) &&
    gp_fall_event == (~gp_input_value & $past(gp_input_value)))
    else $error("gp edge event wrong");
  gp_direct_in_a: assert property (!$past(rst) |-> ((gp_input_value ^ $past(gp_pad_in)) & ~$past(gp_debounce_select)) == 0)
    else $error("gp direct input wrong");
  gp_pad_drive_a: assert property (!$past(rst) && !$past(powered_down) |-> gp_pad_out == $past(gp_output_value) &&
    gp_pad_oe == $past(gp_direction) && gp_pad_pulldown == 0)
    else $error("gp pad drive wrong");
  gp_pad_gate_a: assert property (gp_pad_pulldown != 0 |-> (gp_pad_out & gp_pad_pulldown) == 0 && (gp_pad_oe & gp_pad_pulldown) == 0)
    else $error("gp pad not gated in power-down");
endmodule // gpmf_io_props
bind gpmf_io gpmf_io_props #(.GP_N(GP_N), .MF_N(MF_N)) u_gpmf_io_props (.*);

// ==== gpmf_board.sv ====
/* gpmf_board: board side of one bank of pins, an external driver per pin plus the pad pull-down.
   assumes pad outputs of gpmf_io and a drive pattern set by the bench. */
`timescale 1ns/1ps
module gpmf_board #(
  parameter int unsigned N = 7
) (
  input  wire logic         clk_sys,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pulldown,
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_val,
  output logic      [N-1:0] pad_in
);
  logic [N-1:0] float_q = '0;
  // a floating line wanders every cycle so a stale level never passes for a driven one
  always @(posedge clk_sys) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pulldown[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_q[i];
    end
  end
endmodule // gpmf_board

// ==== gpmf_io_tb_top.sv ====
/* gpmf_io_tb_top: self-checking bench for gpmf_io with a board model on each pin bank.
   assumes the property checker is bound in from its own file. */
`timescale 1ns/1ps
module gpmf_io_tb_top;
  import gpmf_pkg::*;
  localparam int unsigned TK = 4;
  logic        clk_sys = 1'b0, rst = 1'b1, supply_good_main = 1'b1, supply_good_core = 1'b1, powered_down;
  logic        gp_ctrl_load = 1'b0, mf_ctrl_load = 1'b0, bus_master_test = 1'b0, cpu_data_cycle_test = 1'b0;
  logic [6:0]  gp_direction = '0, gp_output_value = '0, gp_debounce_select = '0, gp_powerdown_enable = '0;
  logic [6:0]  gp_pad_in, gp_pad_out, gp_pad_oe, gp_pad_pulldown, gp_input_value, gp_rise_event, gp_fall_event;
  logic [6:0]  gp_ext_en = '1, gp_ext_val = '0;
  logic [31:0] mf_direction = '0, mf_output_value = '0, mf_port_select_in = '0, mf_powerdown_in = '0;
  logic [31:0] func_out = '0, func_oe = '0, mf_ext_en = '1, mf_ext_val = '0;
  logic [31:0] mf_pad_in, mf_pad_out, mf_pad_oe, mf_pad_pulldown, mf_input_value, mf_func_in;
  logic [31:0] mf_port_select_bits, mf_powerdown_bits, mf_rise_event, mf_fall_event;
  logic [11:0] r;
  int          failures = 0, checks = 0, n;
  // row: sel dout dir fo foe pd_bit supply_main supply_core | pad_out pad_oe pulldown
  logic [11:0] rows [8] = '{12'h71e, 12'h4d8, 12'h0de, 12'h318, 12'h3e9, 12'h7f1, 12'h7c6, 12'h7fe};
  gpmf_io #(.TICK_COUNT(TK)) u_gpmf_io (.*);
  gpmf_board #(.N(7)) u_gpmf_board_gp (.clk_sys(clk_sys), .pad_out(gp_pad_out), .pad_oe(gp_pad_oe),
    .pad_pulldown(gp_pad_pulldown), .ext_en(gp_ext_en), .ext_val(gp_ext_val), .pad_in(gp_pad_in));
  gpmf_board #(.N(32)) u_gpmf_board_mf (.clk_sys(clk_sys), .pad_out(mf_pad_out), .pad_oe(mf_pad_oe),
    .pad_pulldown(mf_pad_pulldown), .ext_en(mf_ext_en), .ext_val(mf_ext_val), .pad_in(mf_pad_in));
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk_sys) rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("mf_port_select_bits", 32'hf20f0fff, mf_port_select_bits);
    chk("mf_powerdown_bits", 32'hfaf03fff, mf_powerdown_bits);
    $display("test reset done");
  endtask
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    do_reset();
    @(posedge clk_sys) {gp_ctrl_load, mf_ctrl_load} <= 2'h3;
    foreach (rows[k]) begin
      @(posedge clk_sys);
      r = rows[k];
      mf_port_select_in <= {32{r[10]}};
      {mf_output_value, gp_output_value} <= {39{r[9]}};
      {mf_direction, gp_direction} <= {39{r[8]}};
      {func_out, bus_master_test, cpu_data_cycle_test} <= {34{r[7]}};
      func_oe <= {32{r[6]}};
      {mf_powerdown_in, gp_powerdown_enable} <= {39{r[5]}};
      {supply_good_main, supply_good_core} <= r[4:3];
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("mf_pad_out", {2'h0, {30{r[2]}}}, {2'h0, mf_pad_out[31:2]});
      chk("mf_pad_oe", {2'h0, {30{r[1]}}}, {2'h0, mf_pad_oe[31:2]});
      chk("mf_pad_pulldown", {2'h0, {30{r[0]}}}, {2'h0, mf_pad_pulldown[31:2]});
      chk("gp_pad_out", {25'h0, {7{r[9] & ~r[0]}}}, {25'h0, gp_pad_out});
      chk("gp_pad_pulldown", {25'h0, {7{r[0]}}}, {25'h0, gp_pad_pulldown});
    end
    $display("test pad rows done");
    // pins driven by the block read back what is driven, not the board's opposing level
    @(posedge clk_sys) {gp_direction, gp_output_value, gp_ext_val} <= {7'h7f, 7'h55, 7'h2a};
    {mf_port_select_in, mf_direction, mf_powerdown_in} <= {32'hffffffff, 32'h0, 32'h0};
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) chk("gp_input_value", 32'h55, {25'h0, gp_input_value});
    @(posedge clk_sys) mf_ext_val <= 32'ha5a5a5a5;
    @(posedge clk_sys);
    @(negedge clk_sys) chk("mf_rise_event", 32'ha5a5a5a5, mf_rise_event);
    chk("mf_input_value", 32'ha5a5a5a5, mf_input_value);
    @(negedge clk_sys) chk("mf_rise_event", 32'h0, mf_rise_event);
    @(posedge clk_sys) mf_ext_val <= 32'h0;
    @(posedge clk_sys);
    @(negedge clk_sys) chk("mf_fall_event", 32'ha5a5a5a5, mf_fall_event);
    @(posedge clk_sys) {mf_port_select_in, func_oe} <= 64'h0;
    repeat (4) @(posedge clk_sys);
    mf_ext_val <= 32'h5a5a5a58;
    @(posedge clk_sys);
    @(negedge clk_sys) chk("mf_rise_event", 32'h0, mf_rise_event);
    chk("mf_func_in", 32'h5a5a5a58, {mf_func_in[31:2], 2'h0});
    $display("test mf events done");
    @(posedge clk_sys) {gp_direction, gp_debounce_select, gp_ext_val} <= {7'h0, 7'h7f, 7'h0};
    repeat (120) @(posedge clk_sys);
    gp_ext_val <= 7'h7f;
    n = 0;
    repeat (60) @(posedge clk_sys);
    @(negedge clk_sys) chk("gp_input_value", 32'h0, {25'h0, gp_input_value});
    n = 60;
    while (gp_input_value !== 7'h7f && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk("gp_rise_event", 32'h7f, {25'h0, gp_rise_event});
    chk("debounce_in_window", 32'h1, {31'h0, n >= 16 * TK && n <= 24 * TK + 3});
    $display("test debounce done");
    @(posedge clk_sys) {gp_ctrl_load, mf_ctrl_load} <= 2'h0;
    do_reset();
    finish_test();
  end
endmodule // gpmf_io_tb_top
